/* File: rtl/mute_cfg.svh */
/*
 * Offsets, field positions, reset values and timing counts for the
 * light-curtain muting logic. Assumes a 20 MHz system clock.
 */
`ifndef MUTE_CFG_SVH
`define MUTE_CFG_SVH

// Clock and tick
`define CLK_HZ 20000000
`define TICK_MS 10
`define TICK_CYC ((`CLK_HZ / 1000) * `TICK_MS)

// Register byte offsets
`define A_CTRL 8'h00
`define A_TIME 8'h04
`define A_STAT 8'h08

// Control fields
`define C_MODE_LO 0
`define C_COMPL 2
`define C_RUN 3
`define C_OVR_DUAL 4
`define C_OVR_EN 5

// Time register fields (in 10 ms ticks, except max muting in 500 ms)
`define T_SYNC_LO 0
`define T_DISC_LO 9
`define T_MUTE_LO 15

// Reset values, and ticks per 500 ms step
`define SYNC_DEF 9'd300
`define DISC_DEF 6'd3
`define MUTE_DEF 8'd120
`define CTRL_DEF 6'h00
`define TICKS_PER_500MS 6'd50

`endif

/* File: rtl/mute_core.sv */
/*
 * Light-curtain muting logic with a classic Wishbone register slave.
 * Assumes curtain channels, muting sensors and override pins are
 * asynchronous and sensors read high while they see a workpiece.
 */
// The implementer's own choices: the address map and register access over Wishbone.
// Contract
// R1: Equivalent wiring: permit only when both high
// R2: Complementary: permit only when NC high, NO low
// R3: Discrepancy forces permit off, flags fault and error
// R4: Discrepancy clears on reactivation or idle-run cycle
// R5: While muted, curtain ignored and permit held
// R6: Four selectable muting modes
// R7: Muting needs active curtain, no errors, sensors off
// R8: Order and sync window, except position mode
// R9: Wrong sensor order raises sequence error
// R10: Sensor gap beyond window raises sync error
// R11: Curtain loss before muting drops permit
// R12: Parallel mode ends when 11 or 12 off
// R13: Sequential modes end on three sensors off
// R14: Position mode ends when 11 off
// R15: Max muting time ends muting
// R16: Obstruction after muting end drops permit
// R17: Curtain or override discrepancy ends muting
// R18: Muting restarts when start conditions hold again
// R19: Sensors read high on workpiece, else low
// R20: Override can assert permit without muting
// R21: Max muting 500 ms steps, zero unlimited
// R22: Sync window 10 ms steps, default 3 s
// R23: Sequence check starts after all sensors off
// R24: Discrepancy time 10 ms steps, default 30 ms
// R25: 10 ms tick timers; run entry clears all
`timescale 1ns/1ns
`include "mute_cfg.svh"

module mute_core
  import mute_pkg::*;
(
  input wire logic clk, // System clock, 20 MHz
  input wire logic srst, // Synchronous reset, active high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic [1:0] curtain_in, // Protective curtain channels 1,2
  input wire logic [3:0] sensor_in, // Sensors 11,12,21,22 in bits 0..3
  input wire logic [1:0] override_in, // Override channels
  output logic permit, // Safe output permit
  output logic muting, // Muting status
  output logic fault, // Fault present
  output logic disc_err, // Curtain or override discrepancy
  output logic seq_err, // Sequence error
  output logic sync_err // Synchronization error
);

  typedef struct packed {
    logic [2:0][7:0] sync3;
    logic [7:0] filt;
    logic [5:0] ctrl;
    logic [8:0] sync_t;
    logic [5:0] disc_t;
    logic [7:0] mute_t;
    logic ack;
    logic [31:0] rdat;
    logic [17:0] pres;
    logic tick;
    logic [5:0] cdisc;
    logic [5:0] odisc;
    logic [8:0] scnt;
    logic [13:0] mcnt;
    logic [5:0] m500;
    logic cur_lat;
    logic ovr_lat;
    logic cur_seen_off;
    logic ovr_seen_off;
    logic run_prev;
    logic out_dir;
    mute_e st;
    flags_s fl;
  } state_s;

  state_s s_r;
  state_s s_nxt;

  // Channel pair state: 0 = inactive, 1 = active, 2 = disagree
  function automatic logic [1:0] pair_eval(input logic [1:0] ch,
                                          input logic compl);
    logic [1:0] want;
    want = compl ? 2'b01 : 2'b11;
    if (ch == want) begin
      pair_eval = 2'd1; // [R1] [R2]
    end else if (ch == ~want) begin
      pair_eval = 2'd0;
    end else begin
      pair_eval = 2'd2;
    end
  endfunction : pair_eval

  // One tick step of a discrepancy timer; returns count, top bit = expired
  function automatic logic [6:0] disc_step(input logic [5:0] cnt,
                                          input logic [5:0] lim,
                                          input logic disagree,
                                          input logic tk);
    logic [5:0] c;
    c = cnt;
    if (!disagree) begin
      c = 6'd0;
    end else if (tk && (c != 6'h3f)) begin
      c = c + 6'd1;
    end
    disc_step = {(lim != 6'd0) && disagree && (c >= lim), c}; // [R24]
  endfunction : disc_step

  logic [7:0] raw_in;
  logic [1:0] cur_pair;
  logic [1:0] ovr_pair;
  logic [6:0] cd_step;
  logic [6:0] od_step;
  logic hit;
  logic [31:0] wmask;
  mode_e mode;

  assign raw_in = {override_in, curtain_in, sensor_in};
  assign hit = wb_cyc_i && wb_stb_i && !s_r.ack;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                  {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  always_comb begin
    logic [3:0] sn;
    logic cur_act;
    logic [31:0] v;
    logic run;
    logic start_ok;
    logic end_sens;
    logic errs;
    s_nxt = s_r;
    sn = 4'h0;
    cur_act = 1'b0;
    v = 32'h0000_0000;
    run = 1'b0;
    start_ok = 1'b0;
    end_sens = 1'b0;
    errs = 1'b0;
    mode = MODE_PAR;
    cur_pair = 2'd0;
    ovr_pair = 2'd0;
    cd_step = 7'd0;
    od_step = 7'd0;

    // Three-stage input sync; value moves only when stages 2 and 3 agree
    s_nxt.sync3 = {s_r.sync3[1:0], raw_in};
    for (int i = 0; i < 8; i++) begin
      if (s_r.sync3[1][i] == s_r.sync3[2][i]) begin
        s_nxt.filt[i] = s_r.sync3[2][i];
      end
    end
    sn = s_r.filt[3:0];
    run = s_r.ctrl[`C_RUN];
    unique case (s_r.ctrl[`C_MODE_LO +: 2]) // [R6]
      2'd0: mode = MODE_PAR;
      2'd1: mode = MODE_FWD;
      2'd2: mode = MODE_BOTH;
      2'd3: mode = MODE_POS;
    endcase

    // ************************************************************
    // Register slave
    // ************************************************************
    s_nxt.ack = hit;
    if (hit && wb_we_i) begin
      unique case (wb_adr_i)
        `A_CTRL: begin
          v = {26'd0, s_r.ctrl};
          v = (v & ~wmask) | (wb_dat_i & wmask);
          s_nxt.ctrl = v[5:0];
        end
        `A_TIME: begin
          v = {9'd0, s_r.mute_t, s_r.disc_t, s_r.sync_t};
          v = (v & ~wmask) | (wb_dat_i & wmask);
          s_nxt.sync_t = v[`T_SYNC_LO +: 9]; // [R22]
          s_nxt.disc_t = v[`T_DISC_LO +: 6]; // [R24]
          s_nxt.mute_t = v[`T_MUTE_LO +: 8]; // [R21]
        end
        default: ;
      endcase
    end
    unique case (wb_adr_i)
      `A_CTRL: v = {26'd0, s_r.ctrl};
      `A_TIME: v = {9'd0, s_r.mute_t, s_r.disc_t, s_r.sync_t};
      `A_STAT: v = {22'd0, s_r.st, s_r.fl};
      default: v = 32'h0000_0000;
    endcase
    s_nxt.rdat = hit ? v : 32'h0000_0000;

    // ************************************************************
    // 10 ms tick
    // ************************************************************
    s_nxt.tick = 1'b0;
    s_nxt.pres = s_r.pres + 18'd1;
    if (s_r.pres == 18'(`TICK_CYC - 1)) begin
      s_nxt.pres = 18'd0;
      s_nxt.tick = 1'b1; // [R25]
    end

    // ************************************************************
    // Channel evaluation and discrepancy
    // ************************************************************
    cur_pair = pair_eval(s_r.filt[5:4], s_r.ctrl[`C_COMPL]);
    ovr_pair = pair_eval(s_r.filt[7:6], 1'b0);
    cd_step = disc_step(s_r.cdisc, s_r.disc_t, cur_pair == 2'd2, s_r.tick);
    od_step = disc_step(s_r.odisc, s_r.disc_t,
                        s_r.ctrl[`C_OVR_DUAL] && (ovr_pair == 2'd2),
                        s_r.tick);
    s_nxt.cdisc = cd_step[5:0];
    s_nxt.odisc = od_step[5:0];
    if (cd_step[6]) begin
      s_nxt.cur_lat = 1'b1; // [R3]
      s_nxt.cur_seen_off = 1'b0;
    end else if (s_r.cur_lat) begin
      if (cur_pair == 2'd0) begin
        s_nxt.cur_seen_off = 1'b1;
      end
      if (s_r.cur_seen_off && (cur_pair == 2'd1)) begin
        s_nxt.cur_lat = 1'b0; // [R4]
      end
    end
    if (od_step[6]) begin
      s_nxt.ovr_lat = 1'b1;
      s_nxt.ovr_seen_off = 1'b0;
    end else if (s_r.ovr_lat) begin
      if (ovr_pair == 2'd0) begin
        s_nxt.ovr_seen_off = 1'b1;
      end
      if (s_r.ovr_seen_off && (ovr_pair == 2'd1)) begin
        s_nxt.ovr_lat = 1'b0;
      end
    end
    cur_act = (cur_pair == 2'd1) && !s_r.cur_lat;

    // ************************************************************
    // Muting sequencer
    // ************************************************************
    errs = s_nxt.cur_lat || s_nxt.ovr_lat || s_r.fl.seq_err || s_r.fl.sync_err;
    start_ok = cur_act && !errs; // [R7]
    if (s_r.tick && (s_r.scnt != 9'h1ff)) begin
      s_nxt.scnt = s_r.scnt + 9'd1;
    end
    unique case (s_r.st)
      ST_IDLE: begin
        if (sn == 4'h0) begin
          s_nxt.st = ST_ARM; // [R23]
        end
      end
      ST_ARM: begin
        s_nxt.scnt = 9'd0;
        if (mode == MODE_POS) begin
          if (sn[0] && start_ok) begin
            s_nxt.st = ST_MUTED; // [R8]
          end
        end else if (sn[1] && !sn[0] && !(mode == MODE_BOTH && sn[3])) begin
          s_nxt.fl.seq_err = 1'b1; // [R9]
          s_nxt.st = ST_IDLE;
        end else if (mode == MODE_BOTH && sn[2] && !sn[3]) begin
          s_nxt.fl.seq_err = 1'b1; // [R9]
          s_nxt.st = ST_IDLE;
        end else if (sn[0]) begin
          s_nxt.out_dir = 1'b0;
          s_nxt.st = ST_PAIR;
        end else if (mode == MODE_BOTH && sn[3]) begin
          s_nxt.out_dir = 1'b1;
          s_nxt.st = ST_PAIR;
        end
      end
      ST_PAIR: begin
        if (s_r.scnt > s_r.sync_t) begin
          s_nxt.fl.sync_err = 1'b1; // [R10]
          s_nxt.st = ST_IDLE;
        end else if (s_r.out_dir ? !sn[3] : !sn[0]) begin
          s_nxt.st = ST_IDLE;
        end else if (s_r.out_dir ? sn[2] : sn[1]) begin
          s_nxt.st = start_ok ? ST_MUTED : ST_IDLE; // [R8]
        end
      end
      ST_MUTED: begin
        unique case (mode)
          MODE_PAR: end_sens = !sn[0] || !sn[1]; // [R12]
          MODE_FWD, MODE_BOTH: end_sens = s_r.out_dir ?
            (sn[3:1] == 3'b000) : (sn[2:0] == 3'b000); // [R13]
          MODE_POS: end_sens = !sn[0]; // [R14]
        endcase
        if (end_sens || s_nxt.cur_lat || s_nxt.ovr_lat) begin
          s_nxt.st = ST_IDLE; // [R17] [R18]
        end else if ((s_r.mute_t != 8'd0) && (s_r.mcnt >= 14'(s_r.mute_t)
                     * 14'(`TICKS_PER_500MS))) begin
          s_nxt.st = ST_IDLE; // [R15] [R21]
        end
      end
    endcase
    s_nxt.mcnt = 14'd0;
    if (s_r.st == ST_MUTED) begin
      s_nxt.mcnt = s_r.mcnt + {13'd0, s_r.tick};
    end
    // Errors hold until all sensors off again
    if (sn == 4'h0 && s_r.st == ST_IDLE) begin
      s_nxt.fl.seq_err = 1'b0;
      s_nxt.fl.sync_err = 1'b0;
    end

    // ************************************************************
    // Outputs; run entry wipes errors and timers
    // ************************************************************
    s_nxt.run_prev = run;
    s_nxt.fl.muting = (s_nxt.st == ST_MUTED);
    // While muted the curtain is ignored [R5]; otherwise it rules [R11]
    // [R16]
    s_nxt.fl.permit = run && !s_nxt.cur_lat && !s_nxt.ovr_lat &&
      (s_nxt.fl.muting || cur_act ||
       (s_r.ctrl[`C_OVR_EN] && ovr_pair == 2'd1 && sn != 4'h0)); // [R20]
    s_nxt.fl.disc_err = s_nxt.cur_lat || s_nxt.ovr_lat; // [R3]
    s_nxt.fl.fault = s_nxt.fl.disc_err ||
      ((s_nxt.fl.seq_err || s_nxt.fl.sync_err) && !cur_act);
    if (run && !s_r.run_prev) begin
      s_nxt.cur_lat = 1'b0; // [R4] [R25]
      s_nxt.ovr_lat = 1'b0;
      s_nxt.cdisc = 6'd0;
      s_nxt.odisc = 6'd0;
      s_nxt.fl = '0;
      s_nxt.st = ST_IDLE;
      s_nxt.pres = 18'd0;
    end
    if (!run) begin
      s_nxt.st = ST_IDLE;
      s_nxt.fl.permit = 1'b0;
      s_nxt.fl.muting = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r <= '0;
      s_r.ctrl <= `CTRL_DEF;
      s_r.sync_t <= `SYNC_DEF;
      s_r.disc_t <= `DISC_DEF;
      s_r.mute_t <= `MUTE_DEF;
      s_r.st <= ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wb_dat_o = s_r.rdat;
  assign wb_ack_o = s_r.ack;
  assign permit = s_r.fl.permit;
  assign muting = s_r.fl.muting;
  assign fault = s_r.fl.fault;
  assign disc_err = s_r.fl.disc_err;
  assign seq_err = s_r.fl.seq_err;
  assign sync_err = s_r.fl.sync_err;

endmodule : mute_core

/* File: rtl/mute_pkg.sv */
/*
 * Types for the light-curtain muting logic.
 * Assumes mute_cfg.svh for numbers.
 */
package mute_pkg;

  typedef enum logic [3:0] {
    MODE_PAR = 4'b0001,
    MODE_FWD = 4'b0010,
    MODE_BOTH = 4'b0100,
    MODE_POS = 4'b1000
  } mode_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ARM = 4'b0010,
    ST_PAIR = 4'b0100,
    ST_MUTED = 4'b1000
  } mute_e;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_s;

  typedef struct packed {
    logic fault;
    logic disc_err;
    logic seq_err;
    logic sync_err;
    logic muting;
    logic permit;
  } flags_s;

endpackage : mute_pkg

/* File: testbench/lc_far.sv */
/* Far side: curtain channels and muting sensors.
   Assumes the bench sets channel levels and workpiece presence. */
`timescale 1ns/1ns
module lc_far (
  input wire logic clk, // Clock
  input wire logic [1:0] curt, // Channel levels
  input wire logic [3:0] work, // Workpiece at 11,12,21,22
  output logic [1:0] curtain_in, // Curtain pins
  output logic [3:0] sensor_in // Sensor pins
);
  // Pins take their first level at the first edge, long before reset ends
  always @(posedge clk) begin
    curtain_in <= curt;
    sensor_in <= work;
  end
endmodule : lc_far

/* File: testbench/light_curtain_muting_logic_tb.sv */
/* Self-checking bench for the muting block: registers, wiring,
   the muting modes and order errors.
   Assumes mute_core, the far-side model and a 20 MHz clock. */
`timescale 1ns/1ns
`include "mute_cfg.svh"
module light_curtain_muting_logic_tb
  import mute_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic ack, permit, muting, fault, disc_err, seq_err, sync_err;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdo, rd, t;
  logic [31:0] seed = 32'h0000_002D;
  logic [1:0] curt = 2'h3;
  logic [1:0] ovr = 2'h0;
  logic [1:0] v, curtain_in;
  logic [3:0] work = 4'h0;
  logic [3:0] sensor_in;
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;
  // Rows: mode, two start steps, held pattern, ending pattern
  logic [1:0] md [5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3};
  logic [3:0] s1 [5] = '{4'h1, 4'h1, 4'h1, 4'h8, 4'h1};
  logic [3:0] s2 [5] = '{4'h3, 4'h3, 4'h3, 4'hC, 4'h1};
  logic [3:0] hd [5] = '{4'h3, 4'h4, 4'h4, 4'h2, 4'h1};
  logic [3:0] en [5] = '{4'h2, 4'h8, 4'h8, 4'h1, 4'h2};

  initial begin
    forever #25 clk = ~clk;
  end

  mute_core dut (.clk, .srst, .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdo), .wb_ack_o(ack), .curtain_in, .sensor_in,
    .override_in(ovr), .permit, .muting, .fault, .disc_err, .seq_err,
    .sync_err);
  lc_far far (.clk, .curt, .work, .curtain_in, .sensor_in);

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] r;
    r = s ^ (s << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction : xs

  function automatic logic want(input logic c, input logic [1:0] x);
    return c ? (x == 2'h1) : (x == 2'h3);
  endfunction : want

  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdo;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask : bus

  task automatic settle();
    repeat (8) @(posedge clk);
  endtask : settle

  task automatic chk_reg(input logic [31:0] e, input string m);
    n_checks++;
    if (rd !== e) begin
      fails++;
      $display("MISMATCH t=%0t %s %h", $time, m, rd);
    end
  endtask : chk_reg

  task automatic chk_flags(input flags_s e, input string m);
    flags_s g;
    g = {fault, disc_err, seq_err, sync_err, muting, permit};
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t %s %b", $time, m, g);
    end
  endtask : chk_flags

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      print_verdict();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    bus(1'b0, `A_TIME, 32'h0000_0000);
    chk_reg({9'h000, `MUTE_DEF, `DISC_DEF, `SYNC_DEF}, "time");
    seed = xs(seed);
    // Keep the window nonzero so no order test trips it
    t = (seed & 32'h007F_FFFF) | 32'h0000_0100;
    bus(1'b1, `A_TIME, t);
    bus(1'b0, `A_TIME, 32'h0000_0000);
    chk_reg(t, "time back");
    bus(1'b1, `A_STAT, 32'hFFFF_FFFF);
    bus(1'b0, `A_STAT, 32'h0000_0000);
    chk_reg({22'h00_0000, ST_IDLE, 6'h00}, "status");
    bus(1'b1, 8'h0C, 32'hFFFF_FFFF);
    bus(1'b0, 8'h0C, 32'h0000_0000);
    chk_reg(32'h0000_0000, "hole");
    chk_flags(6'h00, "run off");
    $display("test regs done");
    for (int c = 0; c < 2; c++) begin
      bus(1'b1, `A_CTRL, {28'h000_0000, 1'b1, c[0], 2'h0});
      seed = xs(seed);
      for (int i = 0; i < 4; i++) begin
        v = 2'(i) ^ seed[1:0];
        curt <= v;
        settle();
        chk_flags({5'h00, want(c[0], v)}, "wiring");
      end
    end
    $display("test wiring done");
    curt <= 2'h3;
    foreach (md[r]) begin
      bus(1'b1, `A_CTRL, 32'h0000_0000);
      bus(1'b1, `A_CTRL, {28'h000_0000, 2'h2, md[r]});
      repeat (2) begin
        work <= s1[r];
        settle();
        work <= s2[r];
        settle();
        chk_flags(6'h03, "start");
        curt <= 2'h0;
        settle();
        work <= hd[r];
        settle();
        chk_flags(6'h03, "hold");
        work <= en[r];
        settle();
        chk_flags(6'h00, "end");
        work <= 4'h0;
        curt <= 2'h3;
        settle();
        chk_flags(6'h01, "rearm");
      end
      $display("test mode %0d done", md[r]);
    end
    for (int m = 0; m < 2; m++) begin
      bus(1'b1, `A_CTRL, 32'h0000_0000);
      bus(1'b1, `A_CTRL, {28'h000_0000, 2'h2, 2'(m)});
      work <= 4'h2;
      settle();
      chk_flags(6'h09, "order");
      work <= 4'h3;
      settle();
      chk_flags(6'h09, "no mute");
      curt <= 2'h0;
      settle();
      chk_flags(6'h28, "order blocked");
      work <= 4'h0;
      curt <= 2'h3;
      settle();
      chk_flags(6'h01, "order cleared");
    end
    $display("test order done");
    // Override enabled, parallel mode, curtain obstructed, sensor 21 on
    bus(1'b1, `A_CTRL, 32'h0000_0000);
    bus(1'b1, `A_CTRL, 32'h0000_0028);
    curt <= 2'h0;
    work <= 4'h4;
    ovr <= 2'h3;
    settle();
    chk_flags(6'h01, "override");
    ovr <= 2'h0;
    settle();
    chk_flags(6'h00, "override off");
    $display("test override done");
    print_verdict();
  end
endmodule : light_curtain_muting_logic_tb

/* File: testbench/mute_core_chk.sv */
/* Concurrent checks on the muting block outputs.
   Assumes it is bound to mute_core. */
`timescale 1ns/1ns
`include "mute_cfg.svh"
module mute_core_chk (
  input wire logic clk, // Clock
  input wire logic srst, // Reset
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write
  input wire logic [7:0] wb_adr_i, // Address
  input wire logic [3:0] wb_sel_i, // Lanes
  input wire logic [31:0] wb_dat_i, // Data
  input wire logic wb_ack_o, // Ack
  input wire logic [1:0] curtain_in, // Curtain
  input wire logic [3:0] sensor_in, // Sensors
  input wire logic permit, // Permit
  input wire logic muting, // Muting
  input wire logic fault, // Fault
  input wire logic disc_err, // Discrepancy
  input wire logic seq_err, // Order error
  input wire logic sync_err // Window error
);
  // Shadow taken on the same edge as the slave, so no lag to allow for
  logic [5:0] ctl_r;
  always_ff @(posedge clk) begin
    if (srst)
      ctl_r <= 6'h00;
    else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i
             && wb_adr_i == `A_CTRL && wb_sel_i[0])
      ctl_r <= wb_dat_i[5:0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_equiv_deny: assert property (
    (!ctl_r[`C_COMPL] && !ctl_r[`C_OVR_EN] && !muting
    && curtain_in != 2'h3) [*8] |=> !permit) else $error("equiv permit");
  a_compl_deny: assert property (
    (ctl_r[`C_COMPL] && !ctl_r[`C_OVR_EN] && !muting
    && curtain_in != 2'h1) [*8] |=> !permit) else $error("compl permit");
  a_disc_safe: assert property (
    disc_err |-> fault && !permit) else $error("disc not safe");
  a_disc_unmute: assert property (
    disc_err |-> !muting) else $error("disc while muted");
  a_mute_hold: assert property (
    muting |-> permit) else $error("muted without permit");
  a_mute_entry: assert property (
    $rose(muting) |-> $past(permit) && !seq_err && !sync_err)
    else $error("bad mute entry");
  a_pair_end: assert property (
    (ctl_r[1:0] == 2'h0 && sensor_in[1:0] != 2'h3) [*8] |=> !muting)
    else $error("parallel mute kept");
  a_spot_end: assert property (
    (ctl_r[1:0] == 2'h3 && !sensor_in[0]) [*8] |=> !muting)
    else $error("position mute kept");
endmodule : mute_core_chk
bind mute_core mute_core_chk u_chk (.clk, .srst, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .curtain_in,
  .sensor_in, .permit, .muting, .fault, .disc_err, .seq_err, .sync_err);
